// ---- hw/sdadc_consts.vh ----
// constants for the sigma-delta converter sequencer
//
// Operation
// - ready five conversion clocks after modulator and bias on
// - conversion 2640 clocks plus first delay
// - single converts once, repeat continuously
// - start write triggers conversion
// - active while converting; done cleared on read
// - single mode stops after one conversion
// - repeat clear aborts without end interrupt
// - completion raises interrupt, stores result, valid
// - overwrite sets overrun; result read clears
// - delayed start counted in system clocks
// - delay count bits 31-16, enable bit 0
// - result bits 31-8, previous kept meanwhile
// - done bit 1, active bit 0, reset zero
`ifndef SDADC_CONSTS_VH
`define SDADC_CONSTS_VH

// ==========================================
// timing in conversion clock cycles
`define SDADC_READY_CYC 3'h5
`define SDADC_CONV_CYC 12'ha50
`define SDADC_FIRST_DLY 10'h2a2
`define SDADC_CNT_W 12

// ==========================================
// field layouts
`define SDADC_RES_W 24
`define SDADC_DLY_W 16
`define SDADC_DIV_W 8
`define SDADC_RES_LSB 8
`define SDADC_DLY_LSB 16
`define SDADC_DONE_BIT 1
`define SDADC_ACT_BIT 0
`define SDADC_OVR_BIT 1
`define SDADC_VALID_BIT 0
`define SDADC_ADJ_BIT 0

// ==========================================
// reset values
`define SDADC_ZERO_RES 24'h000000
`define SDADC_ZERO_DLY 16'h0000
`define SDADC_ZERO_DIV 8'h00
`define SDADC_ZERO_CNT 12'h000
`define SDADC_ZERO_WORD 32'h00000000

`endif

// ---- hw/sdadc_clkdiv.v ----
// conversion clock enable generator
`timescale 1ns/100ps
module sdadc_clkdiv
(
    // clock and reset
    input wire mclk_in,
    input wire rst_in,
    // control
    input wire gate_in,
    input wire [7:0] div_in,
    // tick
    output reg tick_out
);
`include "sdadc_consts.vh"

reg [`SDADC_DIV_W-1:0] cnt_r;

// ==========================================
// one tick per div_in+1 system clocks
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        cnt_r <= `SDADC_ZERO_DIV;
        tick_out <= 1'b0;
    end
    else if (gate_in)
    begin
        cnt_r <= `SDADC_ZERO_DIV;
        tick_out <= 1'b0;
    end
    else if (cnt_r >= div_in)
    begin
        cnt_r <= `SDADC_ZERO_DIV;
        tick_out <= 1'b1;
    end
    else
    begin
        cnt_r <= cnt_r + 8'h01;
        tick_out <= 1'b0;
    end
end
endmodule // sdadc_clkdiv

// ---- hw/sdadc_seq.v ----
// sigma-delta converter sequencer top
`timescale 1ns/100ps
module sdadc_seq
(
    // clock and reset
    input wire mclk_in,
    input wire rst_in,
    // power and clock control
    input wire bias_circuit_on_in,
    input wire modulator_on_in,
    input wire converter_clock_gate_in,
    input wire [7:0] conv_clock_divider_in,
    // mode control
    input wire repeat_in,
    input wire [2:0] gain_select_in,
    input wire follower_sync_select_in,
    // start control
    input wire start_wr_in,
    input wire master_start_in,
    input wire [31:0] start_delay_reg_in,
    // read strobes
    input wire status_rd_in,
    input wire result_rd_in,
    // modulator sample data
    input wire [23:0] mod_data_in,
    // status
    output reg [31:0] conv_status_reg_out,
    output reg [31:0] conv_result_reg_out,
    output reg ready_out,
    output reg [2:0] gain_out,
    output reg conv_end_irq_out,
    output reg start_evt_out
);
`include "sdadc_consts.vh"

localparam ST_IDLE = 4'h1;
localparam ST_DLY = 4'h2;
localparam ST_WAIT = 4'h4;
localparam ST_CONV = 4'h8;

wire tick;
reg [3:0] st_r;
reg [3:0] st_nxt;
reg [2:0] rdy_cnt_r;
reg [`SDADC_DLY_W-1:0] dly_cnt_r;
reg [`SDADC_CNT_W-1:0] cnt_r;
reg rpt_seq_r;
reg act_r;
reg done_r;
reg valid_r;
reg ovr_r;
reg [`SDADC_RES_W-1:0] res_r;
reg finish;
reg abort;
wire trigger;
wire start_ok;
wire pwr_on;
wire dly_on;
wire [`SDADC_DLY_W-1:0] dly_val;
wire [`SDADC_CNT_W-1:0] dly_first;

assign dly_on = start_delay_reg_in[`SDADC_ADJ_BIT];
assign dly_val = start_delay_reg_in[`SDADC_DLY_LSB+`SDADC_DLY_W-1:`SDADC_DLY_LSB];
assign dly_first = {2'b00, `SDADC_FIRST_DLY};
// follower starts from master start write
assign trigger = follower_sync_select_in ? master_start_in : start_wr_in;
assign start_ok = (st_r == ST_IDLE) && trigger && ready_out;
assign pwr_on = modulator_on_in && bias_circuit_on_in;

// ==========================================
// conversion clock enable
sdadc_clkdiv u_div
(
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .gate_in(converter_clock_gate_in),
    .div_in(conv_clock_divider_in),
    .tick_out(tick)
);

// ==========================================
// modulator settling count
always @(posedge mclk_in)
begin
    if (rst_in || !pwr_on)
    begin
        rdy_cnt_r <= 3'h0;
    end
    else if (tick && rdy_cnt_r != `SDADC_READY_CYC)
    begin
        rdy_cnt_r <= rdy_cnt_r + 3'h1;
    end
end

// ==========================================
// ready once five conversion clocks have passed
always @(posedge mclk_in)
begin
    if (rst_in || !pwr_on)
    begin
        ready_out <= 1'b0;
    end
    else
    begin
        ready_out <= (rdy_cnt_r == `SDADC_READY_CYC);
    end
end

// ==========================================
// sequencer next state
always @*
begin
    st_nxt = st_r;
    finish = 1'b0;
    abort = 1'b0;
    case (st_r)
        ST_IDLE:
        begin
            if (trigger && ready_out)
            begin
                st_nxt = dly_on ? ST_DLY : ST_WAIT;
            end
        end
        ST_DLY:
        begin
            if (dly_cnt_r == `SDADC_ZERO_DLY)
            begin
                st_nxt = ST_WAIT;
            end
        end
        ST_WAIT:
        begin
            if (tick)
            begin
                st_nxt = ST_CONV;
            end
        end
        ST_CONV:
        begin
            if (tick && cnt_r == `SDADC_CONV_CYC - 12'h001)
            begin
                finish = 1'b1;
                st_nxt = repeat_in ? ST_CONV : ST_IDLE;
            end
        end
        default:
        begin
            st_nxt = ST_IDLE;
        end
    endcase
    // power loss or repeat cleared mid-run: stop with no end pulse
    if (st_r != ST_IDLE && (!ready_out || (rpt_seq_r && !repeat_in)))
    begin
        st_nxt = ST_IDLE;
        finish = 1'b0;
        abort = 1'b1;
    end
end

// ==========================================
// state, active flag, start capture
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        st_r <= ST_IDLE;
        act_r <= 1'b0;
        start_evt_out <= 1'b0;
        gain_out <= 3'h0;
    end
    else
    begin
        st_r <= st_nxt;
        act_r <= (st_nxt != ST_IDLE);
        start_evt_out <= start_ok;
        if (start_ok)
        begin
            gain_out <= gain_select_in;
        end
    end
end

// ==========================================
// repeat sequence tracking
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        rpt_seq_r <= 1'b0;
    end
    else if (abort)
    begin
        rpt_seq_r <= 1'b0;
    end
    else if (start_ok)
    begin
        rpt_seq_r <= repeat_in;
    end
    else if (finish)
    begin
        // a single run turned repeat keeps going
        rpt_seq_r <= repeat_in;
    end
end

// ==========================================
// start delay in system clocks
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        dly_cnt_r <= `SDADC_ZERO_DLY;
    end
    else if (start_ok)
    begin
        dly_cnt_r <= dly_val;
    end
    else if (st_r == ST_DLY && dly_cnt_r != `SDADC_ZERO_DLY)
    begin
        dly_cnt_r <= dly_cnt_r - 16'h0001;
    end
end

// ==========================================
// conversion clock counter
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        cnt_r <= `SDADC_ZERO_CNT;
    end
    else if (st_r == ST_WAIT)
    begin
        // first conversion carries fixed delay
        cnt_r <= `SDADC_ZERO_CNT - dly_first;
    end
    else if (st_r == ST_CONV && tick)
    begin
        if (finish)
        begin
            // later repeat conversions start at zero
            cnt_r <= `SDADC_ZERO_CNT;
        end
        else
        begin
            cnt_r <= cnt_r + 12'h001;
        end
    end
end

// ==========================================
// end pulse and result capture
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        conv_end_irq_out <= 1'b0;
        res_r <= `SDADC_ZERO_RES;
    end
    else
    begin
        conv_end_irq_out <= finish;
        if (finish)
        begin
            res_r <= mod_data_in;
        end
    end
end

// ==========================================
// status flags, set beats read clear
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        done_r <= 1'b0;
        valid_r <= 1'b0;
        ovr_r <= 1'b0;
    end
    else
    begin
        done_r <= finish | (done_r & ~status_rd_in);
        valid_r <= finish | (valid_r & ~result_rd_in);
        ovr_r <= (finish & valid_r) | (ovr_r & ~result_rd_in);
    end
end

// ==========================================
// register images
always @(posedge mclk_in)
begin
    if (rst_in)
    begin
        conv_status_reg_out <= `SDADC_ZERO_WORD;
        conv_result_reg_out <= `SDADC_ZERO_WORD;
    end
    else
    begin
        conv_status_reg_out <= {30'h00000000, done_r, act_r};
        // result field holds until the next finish
        conv_result_reg_out <= {res_r, 6'h00, ovr_r, valid_r};
    end
end
endmodule // sdadc_seq

// ---- verif/sdadc_seq_monitor.sv ----
// port checker for the converter sequencer
`timescale 1ns/100ps
module sdadc_seq_monitor
(
    // clock and reset
    input wire mclk_in,
    input wire rst_in,
    // watched inputs
    input wire modulator_on_in,
    input wire start_wr_in,
    input wire status_rd_in,
    input wire result_rd_in,
    // watched outputs
    input wire [31:0] conv_status_reg_out,
    input wire [31:0] conv_result_reg_out,
    input wire ready_out,
    input wire conv_end_irq_out,
    input wire start_evt_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // ==========================================
    // assertions
    start_shows_a: assert property (start_evt_out |=> conv_status_reg_out[0])
        else $error("active not shown after start");
    end_pulse_a: assert property (conv_end_irq_out |=> !conv_end_irq_out)
        else $error("end pulse too long");
    end_flags_a: assert property (conv_end_irq_out |=> conv_result_reg_out[0] && conv_status_reg_out[1])
        else $error("flags missing after end");
    end_active_a: assert property (conv_end_irq_out |-> $past(conv_status_reg_out[0]))
        else $error("end without conversion");
    status_zero_a: assert property (conv_status_reg_out[31:2] == 30'h0)
        else $error("status spare bits set");
    result_zero_a: assert property (conv_result_reg_out[7:2] == 6'h0)
        else $error("result spare bits set");
    result_clear_a: assert property (result_rd_in ##1 !conv_end_irq_out |=> conv_result_reg_out[1:0] == 2'h0)
        else $error("result read did not clear");
    status_clear_a: assert property (status_rd_in ##1 !conv_end_irq_out |=> !conv_status_reg_out[1])
        else $error("status read did not clear");
    ready_gate_a: assert property (start_wr_in && !ready_out |=> !start_evt_out)
        else $error("start taken before ready");
    ready_late_a: assert property ($rose(ready_out) |-> $past(modulator_on_in, 4))
        else $error("ready too early");
    ready_drop_a: assert property (!modulator_on_in ##1 !modulator_on_in |-> !ready_out)
        else $error("ready without modulator");
endmodule // sdadc_seq_monitor

// ---- verif/sdadc_seq_tb.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sdadc_seq_tb;
    reg mclk_in, rst_in, bias, modu, gate, rpt, sync, start, mstart, srd, rrd;
    reg [7:0] div;
    reg [2:0] gain;
    reg [31:0] dly;
    reg [23:0] mdata;
    wire [31:0] st, res;
    wire [2:0] gout;
    wire ready, irq, sevt;
    integer n_fail, check_count, n, k;
    sdadc_seq dut (.mclk_in(mclk_in), .rst_in(rst_in), .bias_circuit_on_in(bias),
        .modulator_on_in(modu), .converter_clock_gate_in(gate), .conv_clock_divider_in(div),
        .repeat_in(rpt), .gain_select_in(gain), .follower_sync_select_in(sync),
        .start_wr_in(start), .master_start_in(mstart), .start_delay_reg_in(dly),
        .status_rd_in(srd), .result_rd_in(rrd), .mod_data_in(mdata),
        .conv_status_reg_out(st), .conv_result_reg_out(res), .ready_out(ready),
        .gain_out(gout), .conv_end_irq_out(irq), .start_evt_out(sevt));
    // ==========================================
    // tasks
    task check(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                n_fail = n_fail + 1;
                $display("BAD %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task pulse_start(input m);
        begin
            @(negedge mclk_in);
            start = !m;
            mstart = m;
            @(negedge mclk_in);
            start = 0;
            mstart = 0;
        end
    endtask
    // sel 0 waits for ready, 1 for the end pulse
    task wait_sig(input sel, output integer cyc);
        begin
            cyc = 0;
            @(negedge mclk_in);
            while ((sel ? irq : ready) !== 1'b1)
            begin
                @(negedge mclk_in);
                cyc = cyc + 1;
                if (cyc > 20000)
                begin
                    n_fail = n_fail + 1;
                    final_report;
                end
            end
            repeat (2) @(negedge mclk_in);
        end
    endtask
    task rd(input r);
        begin
            @(negedge mclk_in);
            srd = !r;
            rrd = r;
            @(negedge mclk_in);
            srd = 0;
            rrd = 0;
            repeat (2) @(negedge mclk_in);
        end
    endtask
    // ==========================================
    // stimulus
    initial
    begin
        mclk_in = 0;
        forever #2 mclk_in = !mclk_in;
    end
    initial
    begin
        {bias, modu, gate, rpt, sync, start, mstart, srd, rrd} = 9'h000;
        {div, gain, dly, mdata} = 67'h0;
        n_fail = 0;
        check_count = 0;
        rst_in = 1;
        repeat (4) @(posedge mclk_in);
        @(negedge mclk_in);
        rst_in = 0;
        check("status", st, 32'h0);
        check("result", res, 32'h0);
        pulse_start(0);
        // reference and amplifier taken as on and settled, clock running
        bias = 1;
        modu = 1;
        gain = 3'h4;
        mdata = 24'h4fc2bf;
        wait_sig(0, n);
        check("ready", n >= 3 && n <= 8, 1);
        pulse_start(0);
        wait_sig(1, n);
        check("single", n >= 3308 && n <= 3322, 1);
        check("result", res, 32'h4fc2bf01);
        check("status", st, 32'h2);
        check("gain", gout, 3'h4);
        rd(0);
        check("status", st, 32'h0);
        rd(1);
        check("result", res, 32'h4fc2bf00);
        $display("single conversion test done");
        rpt = 1;
        mdata = 24'h000000;
        pulse_start(0);
        wait_sig(1, n);
        check("first", n >= 3308 && n <= 3322, 1);
        wait_sig(1, n);
        check("second", n >= 2634 && n <= 2646, 1);
        check("result", res, 32'h00000003);
        check("active", st[0], 1'b1);
        mdata = 24'h123456;
        rd(1);
        check("keep", res, 32'h00000000);
        rpt = 0;
        k = 0;
        repeat (3000)
        begin
            @(negedge mclk_in);
            k = k + irq;
        end
        check("abort", k, 0);
        check("stopped", st[0], 1'b0);
        rd(1);
        $display("repeat conversion test done");
        sync = 1;
        dly = 32'h00640001;
        mdata = 24'hb03d41;
        pulse_start(0);
        pulse_start(1);
        wait_sig(1, n);
        check("delayed", n >= 3408 && n <= 3422, 1);
        check("result", res[31:8], 24'hb03d41);
        $display("delayed follower start test done");
        // power down while idle, retune the clock, power up again
        check("idle", st[0], 1'b0);
        sync = 0;
        modu = 0;
        repeat (4) @(negedge mclk_in);
        // reference switched off as well
        bias = 0;
        check("unready", ready, 1'b0);
        gate = 1;
        div = 8'h01;
        repeat (4) @(negedge mclk_in);
        gate = 0;
        repeat (4) @(negedge mclk_in);
        bias = 1;
        modu = 1;
        wait_sig(0, n);
        check("slowrdy", n >= 9 && n <= 10, 1);
        $display("power cycle test done");
        final_report;
    end
endmodule // sdadc_seq_tb
bind sdadc_seq sdadc_seq_monitor mon (.mclk_in(mclk_in), .rst_in(rst_in),
    .modulator_on_in(modulator_on_in), .start_wr_in(start_wr_in), .status_rd_in(status_rd_in),
    .result_rd_in(result_rd_in), .conv_status_reg_out(conv_status_reg_out),
    .conv_result_reg_out(conv_result_reg_out), .ready_out(ready_out),
    .conv_end_irq_out(conv_end_irq_out), .start_evt_out(start_evt_out));
